// ---- hw/dual_timer_counter.sv ----
// Purpose: two timer/counters with run, gating, four modes, pin irq flags
// Assumes: AHB-Lite slave, zero wait states, single transfers
// Notes:   vector acks come in as a write of event bits to the ack word
// Function
// R1 - timer1 overflow sets flag, vector clears it
// R2 - timer0 overflow sets flag, vector clears it
// R3 - run bits six and four enable timers
// R4 - irq1 pin falling edge sets flag
// R5 - irq0 pin falling edge sets flag
// R6 - trigger type: zero level, one edge
// R7 - timer1 gate needs irq1 pin high
// R8 - timer0 gate needs irq0 pin high
// R9 - timer mode counts every two clocks
// R10 - counter mode counts count-pin falling edges
// R11 - mode 00 prescaled, mode 01 sixteen bit
// R12 - mode 10 low byte reloads from high
// R13 - mode 11 splits timer0, stops timer1
// R14 - four data bytes readable, writable, reset zero
// R15 - prescaler wrap carries into high byte
`timescale 1ns/100ps
module dual_timer_counter
    import tmr_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        external_irq0_pin,
    input  wire logic        external_irq1_pin,
    input  wire logic        timer0_count_pin,
    input  wire logic        timer1_count_pin,
    output logic             irq0_request,
    output logic             irq1_request,
    output logic             irq
);
    import tmr_pkg::*;

    typedef struct packed {
        logic [7:0]          run_flags;
        logic [7:0]          mode_sel;
        logic [7:0]          t0_low;
        logic [7:0]          t1_low;
        logic [7:0]          t0_high;
        logic [7:0]          t1_high;
        logic [N_EVENTS-1:0] status;
        logic [N_EVENTS-1:0] mask;
        logic                dp_write;
        logic                dp_read;
        logic [7:0]          dp_index;
        logic [31:0]         rdata;
    } tmr_state_t;

    tmr_state_t st;
    tmr_state_t next_st;
    logic       tick;
    logic       t0_fell;
    logic       t1_fell;
    logic       i0_fell;
    logic       i1_fell;

    tick_divider u_tick (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tick    (tick)
    );
    fall_detect u_t0 (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (timer0_count_pin),
        .fell    (t0_fell)
    );
    fall_detect u_t1 (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (timer1_count_pin),
        .fell    (t1_fell)
    );
    fall_detect u_i0 (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (external_irq0_pin),
        .fell    (i0_fell)
    );
    fall_detect u_i1 (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (external_irq1_pin),
        .fell    (i1_fell)
    );

    // gating and source select shared by both timers
    function automatic logic count_step(input logic run, input logic gate,
                                        input logic pin_high, input logic csel,
                                        input logic tick_in, input logic fell);
        logic en;
        en = run & (~gate | pin_high); // R3 R7 R8
        count_step = en & (csel ? fell : tick_in); // R9 R10
    endfunction

    function automatic logic [31:0] word_of(input logic [7:0] b);
        word_of = {24'h000000, b};
    endfunction

    logic       ap_valid;
    logic [7:0] ap_index;
    logic [1:0] m0;
    logic [1:0] m1;
    logic       step0;
    logic       step1;
    logic       step0_hi;
    logic       ovf0;
    logic       ovf1;
    logic [3:0] ev;
    logic [3:0] ack;

    assign ap_valid = hsel & hready & htrans[1];
    assign ap_index = haddr[ADDR_W-1:2] < 10'(256) ? haddr[9:2] : 8'hFF;
    assign m0 = st.mode_sel[B_MODE0_LO+:2];
    assign m1 = st.mode_sel[B_MODE1_LO+:2];

    always_comb begin
        logic [8:0]  lo9;
        logic [8:0]  hi9;
        logic [16:0] w17;
        logic [5:0]  p6;
        logic [7:0]  wb;
        next_st = st;
        lo9 = '0;
        hi9 = '0;
        w17 = '0;
        p6 = '0;
        wb = hwdata[7:0];
        ovf0 = 1'b0;
        ovf1 = 1'b0;
        ack = '0;
        step0 = count_step(st.run_flags[B_TR0], st.mode_sel[B_TIMER0_PIN_GATING], external_irq0_pin,
                           st.mode_sel[B_CSEL0], tick, t0_fell);
        step1 = count_step(st.run_flags[B_TR1], st.mode_sel[B_TIMER1_PIN_GATING], external_irq1_pin,
                           st.mode_sel[B_CSEL1], tick, t1_fell);
        // split high half: always timer-clocked, run by timer1's run bit
        step0_hi = st.run_flags[B_TR1] & tick; // R13

        // timer 0
        if (step0) begin
            case (m0)
                MODE_PRESCALED: begin
                    p6 = {1'b0, st.t0_low[4:0]} + 6'h01;
                    next_st.t0_low = {st.t0_low[7:5], p6[4:0]}; // R11
                    if (st.t0_low[4:0] == PRESCALE_TOP) begin
                        hi9 = {1'b0, st.t0_high} + 9'h001; // R15
                        next_st.t0_high = hi9[7:0];
                        ovf0 = hi9[8];
                    end
                end
                MODE_WIDE16: begin
                    w17 = {1'b0, st.t0_high, st.t0_low} + 17'h00001; // R11
                    {next_st.t0_high, next_st.t0_low} = w17[15:0];
                    ovf0 = w17[16];
                end
                MODE_RELOAD8: begin
                    lo9 = {1'b0, st.t0_low} + 9'h001;
                    next_st.t0_low = lo9[8] ? st.t0_high : lo9[7:0]; // R12
                    ovf0 = lo9[8];
                end
                default: begin
                    lo9 = {1'b0, st.t0_low} + 9'h001; // R13
                    next_st.t0_low = lo9[7:0];
                    ovf0 = lo9[8];
                end
            endcase
        end
        if (m0 == MODE_SPLIT && step0_hi) begin
            hi9 = {1'b0, st.t0_high} + 9'h001; // R13
            next_st.t0_high = hi9[7:0];
            ovf1 = hi9[8];
        end

        // timer 1; mode 11 holds the count
        if (step1) begin
            case (m1)
                MODE_PRESCALED: begin
                    p6 = {1'b0, st.t1_low[4:0]} + 6'h01;
                    next_st.t1_low = {st.t1_low[7:5], p6[4:0]}; // R11
                    if (st.t1_low[4:0] == PRESCALE_TOP) begin
                        lo9 = {1'b0, st.t1_high} + 9'h001; // R15
                        next_st.t1_high = lo9[7:0];
                        ovf1 = ovf1 | (m0 != MODE_SPLIT && lo9[8]);
                    end
                end
                MODE_WIDE16: begin
                    w17 = {1'b0, st.t1_high, st.t1_low} + 17'h00001; // R11
                    {next_st.t1_high, next_st.t1_low} = w17[15:0];
                    ovf1 = ovf1 | (m0 != MODE_SPLIT && w17[16]);
                end
                MODE_RELOAD8: begin
                    lo9 = {1'b0, st.t1_low} + 9'h001;
                    next_st.t1_low = lo9[8] ? st.t1_high : lo9[7:0]; // R12
                    ovf1 = ovf1 | (m0 != MODE_SPLIT && lo9[8]);
                end
                default: begin
                    next_st.t1_low = st.t1_low; // R13
                end
            endcase
        end

        // data phase of a write; a write to a count byte replaces that byte's count step that cycle
        if (st.dp_write) begin
            if (st.dp_index == IDX_RUN_FLAGS) begin
                next_st.run_flags = wb;
            end else if (st.dp_index == IDX_MODE_SEL) begin
                next_st.mode_sel = wb;
            end else if (st.dp_index == IDX_T0_LOW) begin
                next_st.t0_low = wb; // R14
            end else if (st.dp_index == IDX_T1_LOW) begin
                next_st.t1_low = wb; // R14
            end else if (st.dp_index == IDX_T0_HIGH) begin
                next_st.t0_high = wb; // R14
            end else if (st.dp_index == IDX_T1_HIGH) begin
                next_st.t1_high = wb; // R14
            end else if (st.dp_index == IDX_IRQ_MASK) begin
                next_st.mask = wb[N_EVENTS-1:0];
            end else if (st.dp_index == IDX_VECTOR_ACK) begin
                ack = wb[3:0];
            end
        end

        // vector acknowledge clears flags; a new event wins
        if (ack[0]) next_st.run_flags[B_TF0] = 1'b0; // R2
        if (ack[1]) next_st.run_flags[B_TF1] = 1'b0; // R1
        if (ack[2]) next_st.run_flags[B_IE0] = 1'b0; // R5
        if (ack[3]) next_st.run_flags[B_IE1] = 1'b0; // R4
        if (ovf0) next_st.run_flags[B_TF0] = 1'b1; // R2
        if (ovf1) next_st.run_flags[B_TF1] = 1'b1; // R1
        if (st.run_flags[B_IT0] ? i0_fell : ~external_irq0_pin)
            next_st.run_flags[B_IE0] = 1'b1; // R5 R6
        if (st.run_flags[B_IT1] ? i1_fell : ~external_irq1_pin)
            next_st.run_flags[B_IE1] = 1'b1; // R4 R6

        // sticky status, cleared by a read; set beats the clear
        ev = {next_st.run_flags[B_IE1] & ~st.run_flags[B_IE1],
              next_st.run_flags[B_IE0] & ~st.run_flags[B_IE0],
              ovf1, ovf0};
        if (st.dp_read && st.dp_index == IDX_IRQ_STATUS) begin
            next_st.status = '0;
        end
        next_st.status = next_st.status | ev;

        // address phase and read data
        next_st.dp_write = ap_valid & hwrite;
        next_st.dp_read = ap_valid & ~hwrite;
        next_st.dp_index = ap_index;
        next_st.rdata = '0;
        if (ap_valid && !hwrite) begin
            if (ap_index == IDX_RUN_FLAGS) begin
                next_st.rdata = word_of(next_st.run_flags);
            end else if (ap_index == IDX_MODE_SEL) begin
                next_st.rdata = word_of(next_st.mode_sel);
            end else if (ap_index == IDX_T0_LOW) begin
                next_st.rdata = word_of(next_st.t0_low);
            end else if (ap_index == IDX_T1_LOW) begin
                next_st.rdata = word_of(next_st.t1_low);
            end else if (ap_index == IDX_T0_HIGH) begin
                next_st.rdata = word_of(next_st.t0_high);
            end else if (ap_index == IDX_T1_HIGH) begin
                next_st.rdata = word_of(next_st.t1_high);
            end else if (ap_index == IDX_IRQ_STATUS) begin
                next_st.rdata = {28'h0000000, next_st.status};
            end else if (ap_index == IDX_IRQ_MASK) begin
                next_st.rdata = {28'h0000000, next_st.mask};
            end else begin
                next_st.rdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // zero wait states; unmapped words read zero and ignore writes
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st.rdata;
    assign irq0_request = st.run_flags[B_TF0] | st.run_flags[B_IE0];
    assign irq1_request = st.run_flags[B_TF1] | st.run_flags[B_IE1];
    assign irq = |(st.status & st.mask);
endmodule

// ---- hw/fall_detect.sv ----
// Purpose: falling-edge pulse of a pin, from its level one clock earlier
// Assumes: pin synchronous to hclk
// Notes:   reset value high so a pin already low at release is seen as an edge
`timescale 1ns/100ps
module fall_detect (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic pin,
    output logic      fell
);
    typedef struct packed {
        logic prev;
    } edge_state_t;

    edge_state_t st;
    edge_state_t next_st;

    always_comb begin
        next_st.prev = pin;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '1;
        end else begin
            st <= next_st;
        end
    end

    assign fell = st.prev & ~pin;
endmodule

// ---- hw/tick_divider.sv ----
// Purpose: one-cycle enable every TICK_DIV clocks
// Assumes: single clock domain
// Notes:   free running from reset
`timescale 1ns/100ps
module tick_divider
    import tmr_pkg::*;
(
    input  wire logic hclk,
    input  wire logic hresetn,
    output logic      tick
);
    typedef struct packed {
        logic [3:0] cnt;
        logic       tick;
    } div_state_t;

    div_state_t st;
    div_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (st.cnt == 4'(TICK_DIV - 1)) begin
            next_st.cnt = 4'h0;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 4'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;
endmodule

// ---- hw/tmr_pkg.sv ----
// Purpose: constants shared by the dual timer/counter block
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes:   register indices are kept, byte address is index times four
package tmr_pkg;
    localparam logic [7:0]  IDX_RUN_FLAGS   = 8'h88;
    localparam logic [7:0]  IDX_MODE_SEL    = 8'h89;
    localparam logic [7:0]  IDX_T0_LOW      = 8'h8A;
    localparam logic [7:0]  IDX_T1_LOW      = 8'h8B;
    localparam logic [7:0]  IDX_T0_HIGH     = 8'h8C;
    localparam logic [7:0]  IDX_T1_HIGH     = 8'h8D;
    localparam logic [7:0]  IDX_IRQ_STATUS  = 8'h90;
    localparam logic [7:0]  IDX_IRQ_MASK    = 8'h91;
    localparam logic [7:0]  IDX_VECTOR_ACK  = 8'h92;
    localparam int          ADDR_W          = 12;
    // run/flag register bits
    localparam int          B_TF1           = 7;
    localparam int          B_TR1           = 6;
    localparam int          B_TF0           = 5;
    localparam int          B_TR0           = 4;
    localparam int          B_IE1           = 3;
    localparam int          B_IT1           = 2;
    localparam int          B_IE0           = 1;
    localparam int          B_IT0           = 0;
    // mode register bits
    localparam int          B_TIMER1_PIN_GATING         = 7;
    localparam int          B_CSEL1         = 6;
    localparam int          B_MODE1_LO      = 4;
    localparam int          B_TIMER0_PIN_GATING         = 3;
    localparam int          B_CSEL0         = 2;
    localparam int          B_MODE0_LO      = 0;
    localparam logic [1:0]  MODE_PRESCALED  = 2'b00;
    localparam logic [1:0]  MODE_WIDE16     = 2'b01;
    localparam logic [1:0]  MODE_RELOAD8    = 2'b10;
    localparam logic [1:0]  MODE_SPLIT      = 2'b11;
    localparam logic [4:0]  PRESCALE_TOP    = 5'h1F;
    localparam logic [7:0]  REG_RESET       = 8'h00;
    // status/mask layout: 0 t0 ovf, 1 t1 ovf, 2 irq0, 3 irq1
    localparam int          N_EVENTS        = 4;
    // timer tick: one increment per this many system clocks
    localparam int          TICK_DIV        = 2;
    localparam int          CLK_PERIOD_NS   = 20;
endpackage

// ---- sim/dual_timer_counter_chk.sv ----
// Purpose: port checks for the dual timer/counter
// Assumes: one clock, hready tied to hreadyout
// Notes:   flag drops are legal only in a flag or ack write data phase
`timescale 1ns/100ps
module dual_timer_counter_chk
    import tmr_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        external_irq0_pin,
    input wire logic        external_irq1_pin,
    input wire logic        timer0_count_pin,
    input wire logic        timer1_count_pin,
    input wire logic        irq0_request,
    input wire logic        irq1_request,
    input wire logic        irq
);
    logic tk;
    logic wdp;
    assign tk = hsel && hready && htrans[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdp <= 1'b0;
        end else begin
            wdp <= tk && hwrite && (haddr[9:2] == IDX_RUN_FLAGS || haddr[9:2] == IDX_VECTOR_ACK);
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_bus_okay; hreadyout && !hresp; endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or not okay");
    property p_rdata_idle; !$past(tk) |-> hrdata == 32'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside phase");
    property p_rdata_upper; hrdata[31:8] == 24'h0; endproperty
    a_rdata_upper: assert property (p_rdata_upper) else $error("upper read bits set");
    property p_irq0_fall; $fell(external_irq0_pin) |=> irq0_request; endproperty
    a_irq0_fall: assert property (p_irq0_fall) else $error("pin 0 fall lost");
    property p_irq1_fall; $fell(external_irq1_pin) |=> irq1_request; endproperty
    a_irq1_fall: assert property (p_irq1_fall) else $error("pin 1 fall lost");
    property p_irq0_hold; irq0_request && !wdp |=> irq0_request; endproperty
    a_irq0_hold: assert property (p_irq0_hold) else $error("request 0 dropped");
    property p_irq1_hold; irq1_request && !wdp |=> irq1_request; endproperty
    a_irq1_hold: assert property (p_irq1_hold) else $error("request 1 dropped");
    property p_mode_rb;
        tk && hwrite && haddr[9:2] == IDX_MODE_SEL ##2 tk && !hwrite && haddr[9:2] == IDX_MODE_SEL
        |=> hrdata[7:0] == $past(hwdata[7:0], 2);
    endproperty
    a_mode_rb: assert property (p_mode_rb) else $error("mode readback wrong");
endmodule

bind dual_timer_counter dual_timer_counter_chk dual_timer_counter_chk_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .external_irq0_pin, .external_irq1_pin, .timer0_count_pin,
    .timer1_count_pin, .irq0_request, .irq1_request, .irq
);

// ---- sim/dual_timer_counter_tb.sv ----
// Purpose: self-checking bench for the dual timer/counter
// Assumes: zero-wait slave; pins come from the partner model
// Notes:   timed runs stop before counts are read, so reads are stable
`timescale 1ns/100ps
module dual_timer_counter_tb;
    import tmr_pkg::*;
    localparam logic [7:0] REGS [6] = '{IDX_RUN_FLAGS, IDX_MODE_SEL, IDX_T0_LOW,
                                        IDX_T1_LOW, IDX_T0_HIGH, IDX_T1_HIGH};
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, seed;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        i0, i1, c0, c1, irq0_request, irq1_request, irq;
    logic [3:0]  low_req;
    logic [7:0]  r;
    logic [15:0] e;
    int          n_mismatch, n_compared;

    dual_timer_counter dual_timer_counter_i (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .external_irq0_pin(i0),
        .external_irq1_pin(i1), .timer0_count_pin(c0), .timer1_count_pin(c1),
        .irq0_request, .irq1_request, .irq);
    pin_partner pin_partner_i (.hclk, .low_req, .external_irq0_pin(i0),
        .external_irq1_pin(i1), .timer0_count_pin(c0), .timer1_count_pin(c1));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // a run window of n idle clocks spans n+2 edges with the run bit set
    function automatic logic [15:0] ticks(input int n);
        return 16'((n + 2) / TICK_DIV);
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        n_compared++;
        if (g !== x) begin
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
            n_mismatch++;
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'b00};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata[7:0];
    endtask
    task automatic ld(input logic [7:0] m, input logic [7:0] lo, input logic [7:0] hi);
        xfer(1'b1, IDX_MODE_SEL, m);
        xfer(1'b1, IDX_T0_LOW, lo);
        xfer(1'b1, IDX_T0_HIGH, hi);
    endtask
    task automatic run(input logic [7:0] rb, input int n);
        xfer(1'b1, IDX_RUN_FLAGS, rb);
        repeat (n) @(posedge hclk);
        xfer(1'b1, IDX_RUN_FLAGS, 8'h00);
    endtask
    task automatic pulse(input int b, input int k);
        repeat (k) begin
            low_req[b] <= 1'b1;
            @(posedge hclk);
            low_req[b] <= 1'b0;
            repeat (3) @(posedge hclk);
        end
    endtask
    task automatic wrap_up;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        hclk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) hclk = ~hclk;
    end
    initial begin
        #100000;
        n_mismatch++;
        wrap_up;
    end
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, low_req} = '0;
        hsize = 3'b010;
        hresetn = 1'b0;
        seed = 32'hF886;
        n_mismatch = 0;
        n_compared = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 6; i++) begin
            xfer(1'b0, REGS[i], 8'h00);
            chk(r, REG_RESET);
        end
        xfer(1'b0, 8'hBF, 8'h00);
        chk(r, 8'h00);
        for (int i = 2; i < 6; i++) begin
            seed = xs(seed);
            xfer(1'b1, REGS[i], seed[7:0]);
            repeat (6) @(posedge hclk);
            xfer(1'b0, REGS[i], 8'h00);
            chk(r, seed[7:0]);
        end
        seed = xs(seed);
        xfer(1'b1, IDX_MODE_SEL, seed[7:0]);
        xfer(1'b0, IDX_MODE_SEL, 8'h00);
        chk(r, seed[7:0]);
        ld({6'h0, MODE_WIDE16}, 8'hFE, 8'hFF);
        run(8'h10, 40);
        e = 16'hFFFE + ticks(40);
        xfer(1'b0, IDX_T0_LOW, 8'h00);
        chk(r, e[7:0]);
        xfer(1'b0, IDX_T0_HIGH, 8'h00);
        chk(r, e[15:8]);
        chk({7'h0, irq}, 8'h00);
        xfer(1'b1, IDX_IRQ_MASK, 8'h01);
        @(posedge hclk);
        chk({7'h0, irq}, 8'h01);
        xfer(1'b0, IDX_IRQ_STATUS, 8'h00);
        @(posedge hclk);
        chk(r & 8'h01, 8'h01);
        chk({7'h0, irq}, 8'h00);
        // 0x1D plus the ticks wraps the five-bit stage once
        ld({6'h0, MODE_PRESCALED}, 8'hFD, 8'hFF);
        run(8'h10, 20);
        e = {8'hFF, 8'h1D} + ticks(20) + 16'hE0;
        xfer(1'b0, IDX_T0_LOW, 8'h00);
        chk(r, {3'b111, e[4:0]});
        xfer(1'b0, IDX_T0_HIGH, 8'h00);
        chk(r, 8'h00);
        ld({6'h0, MODE_RELOAD8}, 8'hFE, 8'hA0);
        run(8'h10, 20);
        e = 16'hA0 + ticks(20) - 16'd2;
        xfer(1'b0, IDX_T0_LOW, 8'h00);
        chk(r, e[7:0]);
        xfer(1'b0, IDX_T0_HIGH, 8'h00);
        chk(r, 8'hA0);
        ld(8'h33, 8'h00, 8'h00);
        xfer(1'b1, IDX_T1_LOW, 8'h44);
        run(8'h50, 20);
        e = ticks(20);
        xfer(1'b0, IDX_T0_LOW, 8'h00);
        chk(r, e[7:0]);
        xfer(1'b0, IDX_T0_HIGH, 8'h00);
        chk(r, e[7:0]);
        xfer(1'b0, IDX_T1_LOW, 8'h00);
        chk(r, 8'h44);
        ld(8'h55, 8'h00, 8'h00);
        xfer(1'b1, IDX_T1_LOW, 8'h00);
        xfer(1'b1, IDX_RUN_FLAGS, 8'h50);
        pulse(2, 5);
        pulse(3, 3);
        xfer(1'b1, IDX_MODE_SEL, 8'hDD);
        low_req[0] <= 1'b1;
        pulse(2, 3);
        pulse(3, 3);
        xfer(1'b0, IDX_T0_LOW, 8'h00);
        chk(r, 8'd5);
        xfer(1'b0, IDX_T1_LOW, 8'h00);
        chk(r, 8'd6);
        xfer(1'b1, IDX_VECTOR_ACK, 8'h04);
        @(posedge hclk);
        chk({7'h0, irq0_request}, 8'h01);
        low_req[0] <= 1'b0;
        repeat (3) @(posedge hclk);
        xfer(1'b1, IDX_VECTOR_ACK, 8'h04);
        @(posedge hclk);
        chk({7'h0, irq0_request}, 8'h00);
        xfer(1'b1, IDX_RUN_FLAGS, 8'h04);
        low_req[1] <= 1'b1;
        repeat (4) @(posedge hclk);
        chk({7'h0, irq1_request}, 8'h01);
        xfer(1'b1, IDX_VECTOR_ACK, 8'h08);
        repeat (3) @(posedge hclk);
        chk({7'h0, irq1_request}, 8'h00);
        low_req[1] <= 1'b0;
        wrap_up;
    end
endmodule

// ---- sim/pin_partner.sv ----
// Purpose: count and interrupt pins facing the timer block
// Assumes: pins are pulled up, so idle is high
// Notes:   a low request shows on the pin one clock later
`timescale 1ns/100ps
module pin_partner (
    input  wire logic       hclk,
    input  wire logic [3:0] low_req,
    output logic            external_irq0_pin,
    output logic            external_irq1_pin,
    output logic            timer0_count_pin,
    output logic            timer1_count_pin
);
    initial {external_irq0_pin, external_irq1_pin, timer0_count_pin, timer1_count_pin} = 4'hF;
    always @(posedge hclk) begin
        external_irq0_pin <= !low_req[0];
        external_irq1_pin <= !low_req[1];
        timer0_count_pin  <= !low_req[2];
        timer1_count_pin  <= !low_req[3];
    end
endmodule
